/* File: hw/lbo_pkg.sv */
package lbo_pkg;

    // ****************************************************************
    // Register byte offsets.
    // ****************************************************************
    localparam logic [11:0] LBO_CTRL_OFS   = 12'h000;
    localparam logic [11:0] LBO_STATUS_OFS = 12'h004;
    localparam logic [11:0] LBO_WMARK_OFS  = 12'h008;

    // ****************************************************************
    // Control register fields.
    // ****************************************************************
    localparam int LBO_NO_ORDER_POS  = 0;
    localparam int LBO_SYNC_GNT_POS  = 1;
    localparam int LBO_SYNC_BSY_POS  = 2;
    localparam int LBO_HOLD_BUS_POS  = 3;
    localparam int LBO_STYLE_POS     = 4;
    localparam int LBO_CTRL_BITS     = 6;

    // ****************************************************************
    // Reset values and widths.
    // ****************************************************************
    localparam int          LBO_WM_W         = 5;
    localparam logic [LBO_WM_W-1:0] LBO_WMARK_RST = 5'h04;
    localparam logic [1:0]  LBO_STYLE_RST    = 2'h0;

    // ****************************************************************
    // Bus styles, ordering phases and arbitration states.
    // ****************************************************************
    typedef enum logic [1:0]
    {
        LBO_STYLE_ONE   = 2'b00,
        LBO_STYLE_TWO   = 2'b01,
        LBO_STYLE_THREE = 2'b10
    } lbo_style_t;

    typedef enum logic [2:0]
    {
        LBO_ORD_IDLE  = 3'b000,
        LBO_ORD_PDRN  = 3'b001,
        LBO_ORD_READ  = 3'b010,
        LBO_ORD_QDRN  = 3'b011,
        LBO_ORD_DONE  = 3'b100
    } lbo_ord_t;

    typedef enum logic [1:0]
    {
        LBO_ARB_IDLE = 2'b00,
        LBO_ARB_REQ  = 2'b01,
        LBO_ARB_WAIT = 2'b10,
        LBO_ARB_OWN  = 2'b11
    } lbo_arb_t;

endpackage : lbo_pkg

/* File: hw/lbo_arb_sample.sv */
`timescale 1ns/1ns

// ****************************************************************
// Grant and busy sampling for the local bus arbiter.
// ****************************************************************
module lbo_arb_sample
    import lbo_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic sync_mode,
    input  wire logic bus_grant_n,
    input  wire logic bus_busy_n,
    output logic      grant_seen,
    output logic      busy_free
);

    logic [1:0] fall_q;
    logic [1:0] fall_d;
    logic [1:0] rise_q;
    logic [1:0] rise_d;

    // Asynchronous path: falling edge catches, rising edge re-samples.
    always_comb
    begin
        fall_d = {bus_busy_n, bus_grant_n};
        rise_d = fall_q;
    end

    always_ff @(negedge pclk or negedge presetn)
    begin
        if (!presetn)
            fall_q <= 2'h3;
        else
            fall_q <= fall_d; // [RULE_10]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rise_q <= 2'h3;
        else
            rise_q <= rise_d; // [RULE_10]
    end

    // In synchronous mode the arbiter shares this clock, so the pins are taken at the rising edge directly.
    // That is the clock saved against the two-edge chain.
    always_comb
    begin
        if (sync_mode)
        begin
            grant_seen = !bus_grant_n; // [RULE_11]
            busy_free  = bus_busy_n;
        end
        else
        begin
            grant_seen = !rise_q[0]; // [RULE_10]
            busy_free  = rise_q[1];
        end
    end

endmodule : lbo_arb_sample

/* File: hw/lbo_local_bus_order.sv */
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ns

// Overview of operation
// RULE_01 - After a target read is latched, retry non-register target accesses until read done.
// RULE_02 - Drain the PCI-to-local write FIFO before the latched read runs locally.
// RULE_03 - After the local read, drain local-to-PCI writes before returning read data.
// RULE_04 - While draining local-to-PCI writes, retry non-register slave accesses only.
// RULE_05 - When read may complete, accept PCI-to-local then local-to-PCI posted writes again.
// RULE_06 - DMA transfers are never held back by read ordering.
// RULE_07 - With no-ordering set, reads do not wait for the other channel's writes.
// RULE_08 - Request the local bus for a pending read or enough queued write entries.
// RULE_09 - Assert request; on grant with bus free, assert busy and drop request.
// RULE_10 - Style one defaults to asynchronous, double-sampling grant and busy on both edges.
// RULE_11 - Both sync bits set make grant and busy sampled synchronously, saving a clock.
// RULE_12 - The style-one processor must program its arbitration timing mode to asynchronous.
// RULE_13 - With that processor's core disabled, an external arbiter is needed.
// RULE_14 - With hold-bus set, keep local bus ownership across consecutive transactions.
// RULE_15 - Software keeps hold-bus clear for DMA with the style-two memory controller.
// RULE_16 - In style two, assert busy one clock after grant is sampled.
// RULE_17 - Styles two and three default synchronous; both sync bits zero select asynchronous.
// RULE_18 - Other local bus signalling is sampled and driven on the local clock.
module lbo_local_bus_order
    import lbo_pkg::*;
#(
    parameter int WM_W = LBO_WM_W
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              tgt_read_latch,
    input  wire logic              tgt_read_done,
    input  wire logic              tgt_read_returned,
    input  wire logic              slv_read_pending,
    input  wire logic [WM_W-1:0]   pxf_count,
    input  wire logic              qxf_empty,
    input  wire logic              dma_req,
    input  wire logic              xfer_active,
    input  wire logic              bus_grant_n,
    input  wire logic              bus_busy_n,
    output logic                   tgt_retry,
    output logic                   slv_retry,
    output logic                   pxf_accept,
    output logic                   qxf_accept,
    output logic                   read_go,
    output logic                   read_return_ok,
    output logic                   bus_request_n,
    output logic                   bus_busy_out_n,
    output logic                   bus_busy_oe_n,
    output logic                   bus_owned
);

    // ****************************************************************
    // Register file.
    // ****************************************************************
    logic [LBO_CTRL_BITS-1:0] ctrl_q;
    logic [LBO_CTRL_BITS-1:0] ctrl_d;
    logic [WM_W-1:0]          wmark_q;
    logic [WM_W-1:0]          wmark_d;
    logic [31:0]              prdata_q;
    logic [31:0]              prdata_d;
    logic                     pready_q;
    logic                     pready_d;
    logic                     pslverr_q;
    logic                     pslverr_d;
    logic                     acc;
    logic                     hit;
    logic                     no_order;
    logic                     sync_mode;
    logic                     hold_bus;
    lbo_style_t               style;
    lbo_ord_t                 ord_q;
    lbo_ord_t                 ord_d;
    lbo_arb_t                 arb_q;
    lbo_arb_t                 arb_d;

    assign acc       = psel && penable && !pready_q;
    assign hit       = (paddr == LBO_CTRL_OFS) || (paddr == LBO_STATUS_OFS) || (paddr == LBO_WMARK_OFS);
    assign no_order  = ctrl_q[LBO_NO_ORDER_POS];
    assign hold_bus  = ctrl_q[LBO_HOLD_BUS_POS];
    assign style     = lbo_style_t'(ctrl_q[LBO_STYLE_POS +: 2]);
    // Style one needs both bits set; the other styles stay async only when both are clear.
    assign sync_mode = (style == LBO_STYLE_ONE)
                     ? (ctrl_q[LBO_SYNC_GNT_POS] && ctrl_q[LBO_SYNC_BSY_POS])    // [RULE_10] [RULE_11]
                     : (ctrl_q[LBO_SYNC_GNT_POS] || ctrl_q[LBO_SYNC_BSY_POS]);  // [RULE_17]

    always_comb
    begin
        ctrl_d    = ctrl_q;
        wmark_d   = wmark_q;
        prdata_d  = prdata_q;
        pready_d  = acc;
        pslverr_d = acc && !hit;
        if (acc && pwrite && paddr == LBO_CTRL_OFS)
            ctrl_d = pwdata[LBO_CTRL_BITS-1:0];
        if (acc && pwrite && paddr == LBO_WMARK_OFS)
            wmark_d = pwdata[WM_W-1:0];
        if (acc && !pwrite)
        begin
            prdata_d = 32'h0;
            if (paddr == LBO_CTRL_OFS)
                prdata_d[LBO_CTRL_BITS-1:0] = ctrl_q;
            else if (paddr == LBO_STATUS_OFS)
                prdata_d = {25'h0, bus_owned, arb_q, ord_q, tgt_retry};
            else if (paddr == LBO_WMARK_OFS)
                prdata_d[WM_W-1:0] = wmark_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q    <= {LBO_STYLE_RST, 4'h0};
            wmark_q   <= LBO_WMARK_RST;
            prdata_q  <= 32'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            ctrl_q    <= ctrl_d;
            wmark_q   <= wmark_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ****************************************************************
    // Read versus posted write ordering.
    // ****************************************************************
    logic pxf_empty;
    logic tgt_retry_d;
    logic slv_retry_d;
    logic pxf_acc_d;
    logic qxf_acc_d;
    logic read_go_d;
    logic ret_ok_d;
    logic tgt_retry_q;
    logic slv_retry_q;
    logic pxf_acc_q;
    logic qxf_acc_q;
    logic read_go_q;
    logic ret_ok_q;

    assign pxf_empty = (pxf_count == '0);

    always_comb
    begin
        ord_d = ord_q;
        unique case (ord_q)
            LBO_ORD_IDLE:
                if (tgt_read_latch)
                    ord_d = LBO_ORD_PDRN; // [RULE_01] [RULE_02]
            LBO_ORD_PDRN:
                if (pxf_empty)
                    ord_d = LBO_ORD_READ; // [RULE_02]
            LBO_ORD_READ:
                if (tgt_read_done)
                    ord_d = no_order ? LBO_ORD_DONE : LBO_ORD_QDRN; // [RULE_07]
            LBO_ORD_QDRN:
                if (qxf_empty)
                    ord_d = LBO_ORD_DONE; // [RULE_03]
            LBO_ORD_DONE:
                if (tgt_read_returned)
                    ord_d = LBO_ORD_IDLE;
            default:
                ord_d = LBO_ORD_IDLE;
        endcase
    end

    // Retry flags cover only target and slave ports; DMA never sees them.
    always_comb
    begin
        tgt_retry_d = (ord_d == LBO_ORD_PDRN) || (ord_d == LBO_ORD_READ) || (ord_d == LBO_ORD_QDRN); // [RULE_01] [RULE_06]
        slv_retry_d = (ord_d == LBO_ORD_QDRN); // [RULE_04]
        read_go_d   = (ord_d == LBO_ORD_READ);
        ret_ok_d    = (ord_d == LBO_ORD_DONE); // [RULE_03]
        pxf_acc_d   = (ord_d == LBO_ORD_IDLE) || (ord_d == LBO_ORD_DONE); // [RULE_05]
        qxf_acc_d   = (ord_d != LBO_ORD_QDRN); // [RULE_05]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ord_q       <= LBO_ORD_IDLE;
            tgt_retry_q <= 1'b0;
            slv_retry_q <= 1'b0;
            pxf_acc_q   <= 1'b1;
            qxf_acc_q   <= 1'b1;
            read_go_q   <= 1'b0;
            ret_ok_q    <= 1'b0;
        end
        else
        begin
            ord_q       <= ord_d;
            tgt_retry_q <= tgt_retry_d;
            slv_retry_q <= slv_retry_d;
            pxf_acc_q   <= pxf_acc_d;
            qxf_acc_q   <= qxf_acc_d;
            read_go_q   <= read_go_d;
            ret_ok_q    <= ret_ok_d;
        end
    end

    assign tgt_retry      = tgt_retry_q;
    assign slv_retry      = slv_retry_q;
    assign pxf_accept     = pxf_acc_q;
    assign qxf_accept     = qxf_acc_q;
    assign read_go        = read_go_q;
    assign read_return_ok = ret_ok_q;

    // ****************************************************************
    // Local bus arbitration.
    // ****************************************************************
    logic need_bus;
    logic grant_seen;
    logic busy_free;
    logic xfer_sync1_q;
    logic xfer_q;
    logic breq_n_q;
    logic breq_n_d;
    logic bbsy_n_q;
    logic bbsy_n_d;
    logic boe_n_q;
    logic boe_n_d;

    lbo_arb_sample u_sample
    (
        .pclk        (pclk),
        .presetn     (presetn),
        .sync_mode   (sync_mode),
        .bus_grant_n (bus_grant_n),
        .bus_busy_n  (bus_busy_n),
        .grant_seen  (grant_seen),
        .busy_free   (busy_free)
    );

    // A write waits for the watermark so a burst is not split by arbitration.
    assign need_bus = read_go_q || slv_read_pending || dma_req || (pxf_count >= wmark_q); // [RULE_08] [RULE_06]

    always_comb
    begin
        arb_d    = arb_q;
        breq_n_d = breq_n_q;
        bbsy_n_d = bbsy_n_q;
        boe_n_d  = boe_n_q;
        unique case (arb_q)
            LBO_ARB_IDLE:
                if (need_bus)
                begin
                    arb_d    = LBO_ARB_REQ;
                    breq_n_d = 1'b0; // [RULE_09]
                end
            LBO_ARB_REQ:
                if (grant_seen && busy_free)
                begin
                    breq_n_d = 1'b1; // [RULE_09]
                    if (style == LBO_STYLE_TWO)
                        arb_d = LBO_ARB_WAIT; // [RULE_16]
                    else
                    begin
                        arb_d    = LBO_ARB_OWN;
                        bbsy_n_d = 1'b0; // [RULE_09]
                        boe_n_d  = 1'b0;
                    end
                end
            LBO_ARB_WAIT:
            begin
                arb_d    = LBO_ARB_OWN;
                bbsy_n_d = 1'b0; // [RULE_16]
                boe_n_d  = 1'b0;
            end
            LBO_ARB_OWN:
                if (!xfer_q && !need_bus && !hold_bus)
                begin
                    arb_d    = LBO_ARB_IDLE;
                    bbsy_n_d = 1'b1;
                end
                else if (!xfer_q && need_bus && !hold_bus && breq_n_q && bbsy_n_q)
                    arb_d = LBO_ARB_IDLE;
                // Busy stays low between transactions while hold-bus is set. [RULE_14]
        endcase
        if (arb_q == LBO_ARB_IDLE && bbsy_n_q)
            boe_n_d = 1'b1;
    end

    // Completion from the local bus is a pin-side level, so it is synchronised. [RULE_18]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            arb_q        <= LBO_ARB_IDLE;
            breq_n_q     <= 1'b1;
            bbsy_n_q     <= 1'b1;
            boe_n_q      <= 1'b1;
            xfer_sync1_q <= 1'b0;
            xfer_q       <= 1'b0;
        end
        else
        begin
            arb_q        <= arb_d;
            breq_n_q     <= breq_n_d;
            bbsy_n_q     <= bbsy_n_d;
            boe_n_q      <= boe_n_d;
            xfer_sync1_q <= xfer_active;
            xfer_q       <= xfer_sync1_q;
        end
    end

    assign bus_request_n  = breq_n_q;
    assign bus_busy_out_n = bbsy_n_q;
    assign bus_busy_oe_n  = boe_n_q;
    assign bus_owned      = !bbsy_n_q;

endmodule : lbo_local_bus_order

/* File: verification/lbo_assertions.sv */
`timescale 1ns/1ns

// ********
// Checker on the top ports.
// ********
module lbo_chk
    import lbo_pkg::*;
#(
    parameter int WM_W = LBO_WM_W
)
(
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [11:0]     paddr,
    input wire logic [31:0]     pwdata,
    input wire logic            pready,
    input wire logic            tgt_read_latch,
    input wire logic [WM_W-1:0] pxf_count,
    input wire logic            qxf_empty,
    input wire logic            slv_read_pending,
    input wire logic            bus_grant_n,
    input wire logic            bus_busy_n,
    input wire logic            read_go,
    input wire logic            read_return_ok,
    input wire logic            tgt_retry,
    input wire logic            slv_retry,
    input wire logic            pxf_accept,
    input wire logic            bus_request_n,
    input wire logic            bus_busy_out_n,
    input wire logic            bus_busy_oe_n
);
    // Control bits are snooped on the edge the design takes a write, since the checker sees only ports.
    logic [5:0] ctl_q;
    logic [5:0] ctl_d;

    always_comb
    begin
        ctl_d = ctl_q;
        if (psel && penable && !pready && pwrite && paddr == LBO_CTRL_OFS)
            ctl_d = pwdata[5:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl_q <= 6'h00;
        else
            ctl_q <= ctl_d;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_retry_cause: assert property ($rose(tgt_retry) |-> $past(tgt_read_latch))
        else $error("target retry without a latched read");
    a_drain_first: assert property ($rose(read_go) |-> $past(pxf_count) == 0)
        else $error("read started before write queue drained");
    a_qdrain_first: assert property ($rose(read_return_ok) && !ctl_q[0] |-> $past(qxf_empty))
        else $error("read returned before local writes drained");
    a_slv_retry_excl: assert property (slv_retry |-> !read_return_ok)
        else $error("slave retry while read returns");
    a_accept_back: assert property ($rose(read_return_ok) |-> pxf_accept && !slv_retry)
        else $error("posted writes not reopened");
    a_request_need: assert property ($rose(slv_read_pending) && bus_busy_out_n
        |-> ##[1:3] (!bus_request_n || !bus_busy_out_n))
        else $error("no bus request for pending read");
    a_busy_drops_req: assert property ($fell(bus_busy_out_n) |-> bus_request_n && !bus_busy_oe_n)
        else $error("busy taken without dropping request");
    a_busy_on_grant: assert property ($fell(bus_busy_out_n) |-> $past(!bus_grant_n && bus_busy_n))
        else $error("busy taken without grant on a free bus");
    a_hold_keeps: assert property (ctl_q[3] && !bus_busy_out_n |=> !bus_busy_out_n)
        else $error("bus released while hold set");
    a_release_oe: assert property ($rose(bus_busy_out_n) |=> bus_busy_oe_n)
        else $error("busy pin not released after negation");

    c_read_go: cover property ($rose(read_go));
    c_return: cover property ($rose(read_return_ok));
    c_own: cover property ($fell(bus_busy_out_n));
endmodule : lbo_chk

bind lbo_local_bus_order lbo_chk #(.WM_W(WM_W)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .tgt_read_latch, .pxf_count, .qxf_empty, .slv_read_pending, .bus_grant_n, .bus_busy_n,
    .read_go, .read_return_ok, .tgt_retry, .slv_retry, .pxf_accept, .bus_request_n, .bus_busy_out_n,
    .bus_busy_oe_n);

/* File: verification/lbo_arb_model.sv */
`timescale 1ns/1ns

// ********
// Bus arbiter and other master of the local bus.
// ********
module lbo_arb_model
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       bus_request_n,
    input  wire logic       bus_busy_out_n,
    input  wire logic       bus_busy_oe_n,
    input  wire logic       other_busy,
    input  wire logic [3:0] gnt_dly,
    output logic            bus_grant_n,
    output logic            bus_busy_n
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       gnt_q;
    logic       gnt_d;

    // The busy line has a pull-up, so a released line shows only the other master.
    assign bus_busy_n  = bus_busy_oe_n ? !other_busy : bus_busy_out_n;
    assign bus_grant_n = !gnt_q;

    // Grant moves on rising edges only and stays until busy is seen taken.
    always_comb
    begin
        cnt_d = (bus_request_n || !bus_busy_n) ? 4'h0 : cnt_q + 4'h1;
        gnt_d = bus_busy_n && (gnt_q || (!bus_request_n && cnt_q >= gnt_dly));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 4'h0;
            gnt_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            gnt_q <= gnt_d;
        end
    end
endmodule : lbo_arb_model

/* File: verification/tb.sv */
`timescale 1ns/1ns

// ********
// Bench.
// ********
module tb;
    import lbo_pkg::*;
    logic                pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]         paddr = 0;
    logic [31:0]         pwdata = 0, prdata;
    logic                pready, pslverr, tgt_retry, slv_retry, pxf_accept, qxf_accept, read_go;
    logic                read_return_ok, bus_request_n, bus_busy_out_n, bus_busy_oe_n, bus_owned;
    logic                tgt_read_latch = 0, tgt_read_done = 0, tgt_read_returned = 0, slv_read_pending = 0;
    logic                qxf_empty = 1, dma_req = 0, xfer_active = 0, other_busy = 0, bus_grant_n, bus_busy_n;
    logic [LBO_WM_W-1:0] pxf_count = 0;
    int                  n_fail = 0, check_count = 0;

    always #4 pclk = ~pclk;

    lbo_arb_model ARB (.pclk, .presetn, .bus_request_n, .bus_busy_out_n, .bus_busy_oe_n, .other_busy,
        .gnt_dly(4'h2), .bus_grant_n, .bus_busy_n);

    lbo_local_bus_order #(.WM_W(LBO_WM_W)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .tgt_read_latch, .tgt_read_done, .tgt_read_returned, .slv_read_pending,
        .pxf_count, .qxf_empty, .dma_req, .xfer_active, .bus_grant_n, .bus_busy_n, .tgt_retry, .slv_retry,
        .pxf_accept, .qxf_accept, .read_go, .read_return_ok, .bus_request_n, .bus_busy_out_n, .bus_busy_oe_n,
        .bus_owned);

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    // Waits for ownership to reach v and reports how many cycles that took.
    task automatic own(input logic v, output int n);
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (bus_owned !== v && n < 40);
    endtask : own

    task automatic pulse_done(input logic ret);
        @(posedge pclk);
        tgt_read_done     <= !ret;
        tgt_read_returned <= ret;
        @(posedge pclk);
        tgt_read_done     <= 1'b0;
        tgt_read_returned <= 1'b0;
    endtask : pulse_done

    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        apb(1'b0, LBO_CTRL_OFS, 0, r, e);
        chk("ctrl reset", 0, r);
        apb(1'b0, LBO_WMARK_OFS, 0, r, e);
        chk("mark reset", 32'(LBO_WMARK_RST), r);
        apb(1'b1, 12'h010, 32'hffff_ffff, r, e);
        chk("unmapped err", 1, 32'(e));
        wr(LBO_CTRL_OFS, 32'h2f);
        apb(1'b0, LBO_CTRL_OFS, 0, r, e);
        chk("ctrl back", 32'h2f, r);
        wr(LBO_CTRL_OFS, 0);
    endtask : t_regs

    task automatic t_wm();
        int n;
        @(posedge pclk);
        pxf_count <= LBO_WMARK_RST - 5'h01;
        repeat (10) @(negedge pclk);
        chk("req below mark", 1, bus_request_n);
        @(posedge pclk);
        pxf_count <= LBO_WMARK_RST;
        own(1'b1, n);
        chk("own at mark", 1, bus_owned);
        @(posedge pclk);
        pxf_count <= 0;
        own(1'b0, n);
    endtask : t_wm

    task automatic t_order(input logic skip);
        logic [31:0] r;
        logic        e;
        int          n;
        wr(LBO_CTRL_OFS, 32'(skip));
        @(posedge pclk);
        dma_req <= !skip; // Hold stays clear whenever the DMA channel runs.
        own(!skip, n);
        chk("dma free", 0, {tgt_retry, slv_retry});
        @(posedge pclk);
        pxf_count      <= 5'h03;
        qxf_empty      <= 1'b0;
        tgt_read_latch <= 1'b1;
        @(posedge pclk);
        tgt_read_latch <= 1'b0;
        repeat (4) @(negedge pclk);
        chk("read start", 0, read_go);
        chk("tgt retry", 1, tgt_retry);
        chk("px closed", 0, pxf_accept);
        @(posedge pclk);
        pxf_count <= 0;
        for (n = 0; n < 30 && read_go !== 1'b1; n++) @(negedge pclk);
        chk("read go", 1, read_go);
        pulse_done(1'b0);
        repeat (3) @(negedge pclk);
        chk("slv retry", 32'(!skip), slv_retry);
        chk("early return", 32'(skip), read_return_ok);
        apb(1'b0, LBO_CTRL_OFS, 0, r, e);
        chk("reg in drain", 32'(skip), {e, r[30:0]});
        @(posedge pclk);
        qxf_empty <= 1'b1;
        for (n = 0; n < 30 && read_return_ok !== 1'b1; n++) @(negedge pclk);
        chk("return ok", 1, read_return_ok);
        chk("px open", 1, pxf_accept);
        chk("slv free", 0, slv_retry);
        pulse_done(1'b1);
        repeat (3) @(negedge pclk);
        chk("qx open", 1, qxf_accept);
        chk("tgt free", 0, tgt_retry);
        @(posedge pclk);
        dma_req <= 1'b0;
        own(1'b0, n);
    endtask : t_order

    task automatic lat(input logic [31:0] ctl, output int n);
        int m;
        wr(LBO_CTRL_OFS, ctl);
        @(posedge pclk);
        slv_read_pending <= 1'b1;
        own(1'b1, n);
        @(posedge pclk);
        slv_read_pending <= 1'b0;
        own(1'b0, m);
    endtask : lat

    // Async sampling costs one cycle more; style two adds one cycle of busy delay.
    task automatic t_arb();
        int          s1, a1, n;
        logic [31:0] ctl [4] = '{32'h02, 32'h20, 32'h22, 32'h16};
        lat(32'h06, s1);
        lat(32'h00, a1);
        chk("async extra", s1 + 1, a1);
        for (int i = 0; i < 4; i++)
        begin
            lat(ctl[i], n);
            chk("style lat", (i < 2) ? a1 : s1 + i - 2, n);
        end
    endtask : t_arb

    task automatic t_hold();
        int n;
        wr(LBO_CTRL_OFS, 32'h08);
        @(posedge pclk);
        other_busy       <= 1'b1;
        slv_read_pending <= 1'b1;
        repeat (10) @(negedge pclk);
        chk("own while busy", 0, bus_owned);
        @(posedge pclk);
        other_busy <= 1'b0;
        own(1'b1, n);
        chk("own when free", 1, bus_owned);
        @(posedge pclk);
        xfer_active <= 1'b1;
        repeat (4) @(posedge pclk);
        xfer_active      <= 1'b0;
        slv_read_pending <= 1'b0;
        repeat (12) @(negedge pclk);
        chk("hold keeps", 1, bus_owned);
        wr(LBO_CTRL_OFS, 0);
        own(1'b0, n);
        chk("hold off", 0, bus_owned);
    endtask : t_hold

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_wm();
        t_order(1'b0);
        t_order(1'b1);
        t_arb();
        t_hold();
        conclude();
    end

    initial
    begin
        #100000;
        n_fail++;
        conclude();
    end
endmodule : tb
